/* core/eeprom_config_timebase.v */
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
`include "eeprom_cfg_consts.vh"
//
// Function
// - 512-byte non-volatile array mapped into the bus, no external high voltage
// - internal charge pump enabled only during program or erase cycle
// - 8-bit config byte and 16-bit divider word hold non-volatile defaults
// - non-volatile config written only by program/erase sequence, not plain writes
// - every reset copies non-volatile configuration into volatile registers
// - active configuration comes from volatile registers
// - config byte mirrored at reset into read-only array configuration register
// - divider high/low non-volatile bytes mirrored into active divider registers
// - program/erase timed from 35 us timebase tick of internal divider
// - divider input is crystal reference or bus clock, by select bit
// - 11-bit divide ratio taken from divider register pair (high bits 2..0 and low byte)
// - block protect takes effect after reset and on config byte read
module eeprom_config_timebase #(
    parameter AUTO_TICKS = `AUTO_TICKS
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire crystal_reference_clock,
    output reg charge_pump_on,
    output reg timebase_tick,
    output reg [3:0] block_protect_bits,
    output reg secure_area_lock
);
    // one load state per cell read plus one more, since cell data lags its address by a cycle
    localparam [5:0] ST_LOAD0 = 6'h01;
    localparam [5:0] ST_LOAD1 = 6'h02;
    localparam [5:0] ST_LOAD2 = 6'h04;
    localparam [5:0] ST_LOAD3 = 6'h08;
    localparam [5:0] ST_IDLE = 6'h10;
    localparam [5:0] ST_WAIT = 6'h20;
    // non-volatile config locations sit just above the array in the cell memory
    localparam [9:0] NV_DIVH = 10'h200;
    localparam [9:0] NV_DIVL = 10'h201;
    localparam [9:0] NV_PROT = 10'h202;

    // word index of a byte address: offsets are not word aligned, so index*4
    function [15:0] widx;
        input [31:0] a;
        begin
            widx = a[17:2];
        end
    endfunction

    // sequencer state and the volatile configuration copies
    reg [5:0] st_r;
    reg [7:0] divh_r;
    reg [7:0] divl_r;
    reg [7:0] prot_mir_r;
    reg [7:0] ctrl_r;
    reg src_sel_r;
    // program latch: target and data held through the high-voltage cycle and after it, until the latch bit is cleared
    reg [9:0] lat_addr_r;
    reg [7:0] lat_data_r;
    reg lat_valid_r;
    // timebase divider and count of ticks in the current cycle
    reg [15:0] div_cnt_r;
    reg [15:0] tick_cnt_r;
    // crystal synchroniser; third flop only feeds the edge detector
    reg x_s1_r;
    reg x_s2_r;
    reg x_s3_r;
    reg rd_pend_r;
    // cell memory port
    reg [9:0] mem_addr;
    wire [7:0] mem_rdata;
    reg mem_prog;
    reg mem_erase;
    // bus decode
    wire [15:0] idx = widx(paddr);
    wire setup = psel & ~penable;
    wire access_phase = psel & penable;
    // only a read of the config byte may refresh protection
    wire prot_read = rd_pend_r && !pwrite && (idx == `IDX_PROT_NV);
    wire in_array = (idx >= `ARRAY_BASE) && (idx < `ARRAY_BASE + `ARRAY_BYTES);
    wire is_nv = (idx == `IDX_DIV_HI_NV) || (idx == `IDX_DIV_LO_NV) || (idx == `IDX_PROT_NV);
    wire [9:0] req_addr = (idx == `IDX_DIV_HI_NV) ? NV_DIVH : (idx == `IDX_DIV_LO_NV) ? NV_DIVL :
        (idx == `IDX_PROT_NV) ? NV_PROT : {1'b0, idx[8:0]};
    wire div_locked = ~divh_r[`DIVH_LOCK];
    wire [15:0] div_ratio = {5'h00, divh_r[2:0], divl_r};
    wire src_edge = x_s2_r & ~x_s3_r;
    wire div_step = src_sel_r ? 1'b1 : src_edge;

    eeprom_cell_array #(.AW(10), .DEPTH(1024)) u_cells (
        .pclk(pclk),
        .addr(mem_addr),
        .prog(mem_prog),
        .erase(mem_erase),
        .wdata(lat_data_r),
        .rdata(mem_rdata)
    );

    // protection check for a latched target address
    function protected_addr;
        input [9:0] a;
        input [7:0] prot;
        begin
            if (a[9]) begin
                protected_addr = ~prot[`PROT_SEC] || (a == NV_DIVH || a == NV_DIVL) & div_locked;
            end else begin
                protected_addr = prot[a[8:7]] == 1'b0 || (~prot[`PROT_SEC] && a[8:4] == 5'h0F);
            end
        end
    endfunction

    // cell access address: reset loader, then bus/latched target
    always @* begin
        mem_prog = 1'b0;
        mem_erase = 1'b0;
        case (st_r)
            ST_LOAD0: mem_addr = NV_DIVH;
            ST_LOAD1: mem_addr = NV_DIVL;
            ST_LOAD2: mem_addr = NV_PROT;
            ST_WAIT: begin
                mem_addr = lat_addr_r;
                // cells change only at end of a high-voltage cycle
                // manual cycles never touch the cells; only the timed auto completion does
                if (ctrl_r[`CTRL_AUTO] && tick_cnt_r == AUTO_TICKS && timebase_tick &&
                    ~protected_addr(lat_addr_r, prot_mir_r)) begin
                    mem_erase = ctrl_r[`CTRL_ERS0] | ctrl_r[`CTRL_ERS1];
                    mem_prog = ~mem_erase;
                end
            end
            default: mem_addr = req_addr;
        endcase
    end

    // crystal reference passes two flops before edge detection
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            x_s1_r <= 1'b0;
            x_s2_r <= 1'b0;
            x_s3_r <= 1'b0;
        end else begin
            x_s1_r <= crystal_reference_clock;
            x_s2_r <= x_s1_r;
            x_s3_r <= x_s2_r;
        end
    end

    // timebase divider: counts selected source edges up to the ratio
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= 16'h0000;
            timebase_tick <= 1'b0;
        end else begin
            timebase_tick <= 1'b0;
            if (st_r != ST_WAIT) begin
                div_cnt_r <= 16'h0000;
            end else if (div_step) begin
                if (div_cnt_r + 16'h0001 >= div_ratio) begin
                    div_cnt_r <= 16'h0000;
                    timebase_tick <= 1'b1;
                end else begin
                    div_cnt_r <= div_cnt_r + 16'h0001;
                end
            end
        end
    end

    // load sequence, control register, latches and high-voltage cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_LOAD0;
            divh_r <= 8'h00;
            divl_r <= 8'h00;
            prot_mir_r <= 8'h00;
            ctrl_r <= `CTRL_RESET;
            src_sel_r <= 1'b0;
            lat_addr_r <= 10'h000;
            lat_data_r <= 8'h00;
            lat_valid_r <= 1'b0;
            tick_cnt_r <= 16'h0000;
            charge_pump_on <= 1'b0;
            block_protect_bits <= 4'h0;
            secure_area_lock <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            rd_pend_r <= 1'b0;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            rd_pend_r <= 1'b0;
            case (st_r)
                // cell read data lags address by one cycle, hence the pipelined copy
                ST_LOAD0: st_r <= ST_LOAD1;
                ST_LOAD1: begin
                    divh_r <= mem_rdata & `DIVH_MASK;
                    st_r <= ST_LOAD2;
                end
                ST_LOAD2: begin
                    divl_r <= mem_rdata;
                    st_r <= ST_LOAD3;
                end
                ST_LOAD3: begin
                    // config byte was addressed in the previous state
                    prot_mir_r <= mem_rdata;
                    st_r <= ST_IDLE;
                end
                ST_WAIT: begin
                    // auto mode ends after the timed count of 35 us ticks
                    if (timebase_tick) begin
                        tick_cnt_r <= tick_cnt_r + 16'h0001;
                    end
                    if ((ctrl_r[`CTRL_AUTO] && tick_cnt_r == AUTO_TICKS && timebase_tick) || ~ctrl_r[`CTRL_GO]) begin
                        ctrl_r[`CTRL_GO] <= 1'b0;
                        charge_pump_on <= 1'b0;
                        st_r <= ST_IDLE;
                    end
                end
                default: ;
            endcase
            // protection reloads on a read of the config byte; a write only latches
            if (st_r == ST_IDLE && prot_read) begin
                prot_mir_r <= mem_rdata;
            end
            // active outputs follow the volatile copies only
            block_protect_bits <= prot_mir_r[3:0];
            secure_area_lock <= ~prot_mir_r[`PROT_SEC];
            // APB: answer two cycles after setup so the registered cell read is ready
            if (setup && (st_r == ST_IDLE || st_r == ST_WAIT)) begin
                rd_pend_r <= 1'b1;
            end
            if (rd_pend_r && access_phase && !pready) begin
                pready <= 1'b1;
                prdata <= 32'h00000000;
                if (!pwrite) begin
                    if (in_array || is_nv) begin
                        prdata[7:0] <= (lat_valid_r && lat_addr_r == req_addr) ? lat_data_r : mem_rdata;
                    end else begin
                        case (idx)
                            `IDX_DIV_HI: prdata[7:0] <= divh_r & `DIVH_MASK;
                            `IDX_DIV_LO: prdata[7:0] <= divl_r;
                            `IDX_CTRL: prdata[7:0] <= ctrl_r;
                            `IDX_PROT_MIR: prdata[7:0] <= prot_mir_r;
                            `IDX_SRC_SEL: prdata[0] <= src_sel_r;
                            `IDX_STATUS: prdata[1:0] <= {lat_valid_r, charge_pump_on};
                            default: pslverr <= 1'b1;
                        endcase
                    end
                end else begin
                    if (in_array || is_nv) begin
                        // plain writes only latch; cells change via the go sequence
                        if (ctrl_r[`CTRL_LATCH] && st_r == ST_IDLE) begin
                            lat_addr_r <= req_addr;
                            lat_data_r <= pwdata[7:0];
                            lat_valid_r <= 1'b1;
                        end
                    end else begin
                        case (idx)
                            `IDX_DIV_HI: if (!div_locked) divh_r <= pwdata[7:0] & `DIVH_MASK;
                            `IDX_DIV_LO: if (!div_locked) divl_r <= pwdata[7:0];
                            `IDX_SRC_SEL: src_sel_r <= pwdata[0];
                            `IDX_CTRL: begin
                                ctrl_r <= pwdata[7:0] & `CTRL_MASK;
                                // go needs latch set and a valid latched target
                                if (pwdata[`CTRL_GO] && !(pwdata[`CTRL_LATCH] && lat_valid_r)) begin
                                    ctrl_r[`CTRL_GO] <= 1'b0;
                                end else if (pwdata[`CTRL_GO] && st_r == ST_IDLE && !pwdata[`CTRL_OFF]) begin
                                    charge_pump_on <= 1'b1;
                                    tick_cnt_r <= 16'h0000;
                                    st_r <= ST_WAIT;
                                end
                                // clearing go and latch together only clears go
                                if (ctrl_r[`CTRL_GO] && !pwdata[`CTRL_GO]) begin
                                    ctrl_r[`CTRL_LATCH] <= ctrl_r[`CTRL_LATCH];
                                end else if (!pwdata[`CTRL_LATCH]) begin
                                    lat_valid_r <= 1'b0;
                                end
                            end
                            `IDX_PROT_MIR, `IDX_STATUS: ; // read only
                            default: pslverr <= 1'b1;
                        endcase
                    end
                end
            end
        end
    end
endmodule

/* common/eeprom_cfg_consts.vh */
`ifndef EEPROM_CFG_CONSTS_VH
`define EEPROM_CFG_CONSTS_VH
// register indices: not every offset is word aligned, so the byte address is index*4
`define IDX_DIV_HI_NV 16'hFE10
`define IDX_DIV_LO_NV 16'hFE11
`define IDX_DIV_HI 16'hFE1A
`define IDX_DIV_LO 16'hFE1B
`define IDX_PROT_NV 16'hFE1C
`define IDX_CTRL 16'hFE1D
`define IDX_PROT_MIR 16'hFE1F
`define IDX_SRC_SEL 16'hFE20
`define IDX_STATUS 16'hFE21
// array window, byte index
`define ARRAY_BASE 16'h0800
`define ARRAY_BYTES 512
`define ARRAY_AW 9
// control bits
`define CTRL_GO 0
`define CTRL_AUTO 1
`define CTRL_LATCH 2
`define CTRL_ERS0 3
`define CTRL_ERS1 4
`define CTRL_OFF 5
`define CTRL_MASK 8'h3F
`define CTRL_RESET 8'h00
// divider high: bit 7 lock, bits 2..0 ratio, bits 6..3 read zero
`define DIVH_LOCK 7
`define DIVH_MASK 8'h87
`define PROT_SEC 4
`define BLANK_BYTE 8'hFF
// timebase
`define TICK_NS 35000
`define CLK_NS 8
`define AUTO_TICKS 16'h0064
`endif

/* core/eeprom_cell_array.v */
`timescale 1ns/1ns
`include "eeprom_cfg_consts.vh"
// byte-wide non-volatile array model: registered read, program clears bits, erase sets them
module eeprom_cell_array #(
    parameter AW = 9,
    parameter DEPTH = 512
) (
    input wire pclk,
    input wire [AW-1:0] addr,
    input wire prog,
    input wire erase,
    input wire [7:0] wdata,
    output reg [7:0] rdata
);
    reg [7:0] mem [0:DEPTH-1];
    integer i;

    initial begin
        for (i = 0; i < DEPTH; i = i + 1) begin
            mem[i] = `BLANK_BYTE;
        end
    end

    // programming only drives ones to zeros; erase restores the blank state
    always @(posedge pclk) begin
        if (erase) begin
            mem[addr] <= `BLANK_BYTE;
        end else if (prog) begin
            mem[addr] <= mem[addr] & wdata;
        end
        rdata <= mem[addr];
    end
endmodule

/* tb/eeprom_cfg_assertions.sv */
`timescale 1ns/1ns
`include "eeprom_cfg_consts.vh"
module eeprom_cfg_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire timebase_tick
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a setup cycle must be answered within a short fixed window
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        ##[1:3] pready;
    endsequence
    a_answer_time: assert property (setup_s |-> answer_s) else $error("setup not answered");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than a cycle");
    a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_array_ok: assert property (pready && paddr[17:2] >= 16'h0800 && paddr[17:2] <= 16'h09FF |-> !pslverr)
        else $error("array access refused");
    a_divh_zero: assert property (pready && !pwrite && paddr[17:2] == `IDX_DIV_HI |-> prdata[6:3] == 4'h0)
        else $error("divider high bits 6..3 not zero");
    a_ctrl_top: assert property (pready && !pwrite && paddr[17:2] == `IDX_CTRL |-> prdata[7:6] == 2'h0)
        else $error("control top bits not zero");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper data set");
    a_tick_pulse: assert property (timebase_tick |=> !timebase_tick) else $error("tick longer than a cycle");
endmodule
bind eeprom_config_timebase eeprom_cfg_checker eeprom_cfg_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timebase_tick(timebase_tick));

/* tb/tb.sv */
`timescale 1ns/1ns
`include "eeprom_cfg_consts.vh"
module tb;
    reg pclk = 1'h0;
    reg presetn = 1'h0;
    reg psel = 1'h0;
    reg penable = 1'h0;
    reg pwrite = 1'h0;
    reg [31:0] paddr = 32'h0;
    reg [31:0] pwdata = 32'h0;
    reg crystal_reference_clock = 1'h0;
    reg [1:0] xcnt = 2'h0;
    reg pump_seen = 1'h0;
    wire [31:0] prdata;
    wire pready, pslverr, charge_pump_on, timebase_tick, secure_area_lock;
    wire [3:0] block_protect_bits;
    integer err_count = 0;
    integer total_checks = 0;
    integer n;
    reg [7:0] rd;
    reg er;
    eeprom_config_timebase #(.AUTO_TICKS(2)) eeprom_config_timebase_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .crystal_reference_clock(crystal_reference_clock), .charge_pump_on(charge_pump_on),
        .timebase_tick(timebase_tick), .block_protect_bits(block_protect_bits), .secure_area_lock(secure_area_lock));
    // 125 MHz bus clock
    initial begin
        forever #4 pclk = ~pclk;
    end
    // crystal at a quarter of the bus rate; pump is a level, so latch any sighting
    always @(posedge pclk) begin
        xcnt <= xcnt + 2'h1;
        crystal_reference_clock <= xcnt[1];
        pump_seen <= pump_seen | (charge_pump_on === 1'h1);
    end
    task wrap_up;
        begin
            $display("checks %0d errors %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
                err_count = err_count + 1;
            end
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task bus(input w, input [15:0] idx, input [7:0] wd);
        integer k;
        begin
            @(posedge pclk);
            psel <= 1'h1;
            penable <= 1'h0;
            pwrite <= w;
            paddr <= {14'h0, idx, 2'h0};
            pwdata <= {24'h0, wd};
            @(posedge pclk);
            penable <= 1'h1;
            k = 0;
            @(posedge pclk);
            while (pready !== 1'h1 && k < 20) begin
                @(posedge pclk);
                k = k + 1;
            end
            rd = prdata[7:0];
            er = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
            if (k >= 20) begin
                chk(16'h0, 16'h1);
                wrap_up;
            end
        end
    endtask
    // read and compare byte plus error flag
    task rc(input [15:0] idx, input [7:0] exp);
        begin
            bus(1'h0, idx, 8'h00);
            chk({7'h0, er, rd}, {8'h0, exp});
        end
    endtask
    task rst;
        begin
            presetn <= 1'h0;
            repeat (20) @(posedge pclk);
            presetn <= 1'h1;
            repeat (4) @(posedge pclk);
        end
    endtask
    // cycles up to the next tick, bounded
    task tk;
        begin
            n = 1;
            @(posedge pclk);
            while (timebase_tick !== 1'h1 && n < 5000) begin
                @(posedge pclk);
                n = n + 1;
            end
        end
    endtask
    task period(input [15:0] exp);
        begin
            tk;
            tk;
            chk(n, exp);
            if (n >= 5000) wrap_up;
        end
    endtask
    task t_reset_vals;
        begin
            rc(`IDX_DIV_HI, 8'h87);
            rc(`IDX_DIV_LO, 8'hFF);
            rc(`IDX_PROT_NV, 8'hFF);
            rc(`IDX_CTRL, `CTRL_RESET);
            rc(`IDX_PROT_MIR, 8'hFF);
            chk({block_protect_bits, 3'h0, secure_area_lock}, 16'h00F0);
            rc(`ARRAY_BASE, `BLANK_BYTE);
            bus(1'h0, 16'h0700, 8'h00);
            chk(er, 16'h1);
        end
    endtask
    task t_writes;
        begin
            bus(1'h1, `IDX_PROT_MIR, 8'h00);
            rc(`IDX_PROT_MIR, 8'hFF);
            bus(1'h1, `IDX_PROT_NV, 8'h00);
            rc(`IDX_PROT_NV, 8'hFF);
            bus(1'h1, `IDX_DIV_HI, 8'hFF);
            rc(`IDX_DIV_HI, 8'h87);
            bus(1'h1, `IDX_CTRL, 8'h3F);
            rc(`IDX_CTRL, 8'h3E);
            bus(1'h1, `IDX_CTRL, 8'h00);
        end
    endtask
    // divider only runs inside a cycle, so a manual cycle is held open; lock bit kept at one
    task t_timebase;
        begin
            bus(1'h1, `IDX_SRC_SEL, 8'h01);
            bus(1'h1, `IDX_DIV_HI, 8'h80);
            bus(1'h1, `IDX_DIV_LO, 8'h10);
            bus(1'h1, `IDX_CTRL, 8'h04);
            bus(1'h1, `ARRAY_BASE + 16'h0001, 8'h5A);
            bus(1'h1, `IDX_CTRL, 8'h05);
            rc(`IDX_STATUS, 8'h03);
            period(16'd16);
            bus(1'h1, `IDX_SRC_SEL, 8'h00);
            bus(1'h1, `IDX_DIV_LO, 8'h03);
            period(16'd12);
            // crystal at 31.25 MHz: int(31.25e6 * 35e-6 + 0.5) = 1094, four bus cycles per edge
            bus(1'h1, `IDX_DIV_HI, 8'h84);
            bus(1'h1, `IDX_DIV_LO, 8'h46);
            period(16'd4376);
            bus(1'h1, `IDX_SRC_SEL, 8'h01);
            bus(1'h1, `IDX_DIV_HI, 8'h80);
            bus(1'h1, `IDX_DIV_LO, 8'h10);
            bus(1'h1, `IDX_CTRL, 8'h04);
            bus(1'h1, `IDX_CTRL, 8'h00);
            rc(`IDX_STATUS, 8'h00);
        end
    endtask
    task t_program;
        integer k;
        begin
            bus(1'h1, `IDX_CTRL, 8'h06);
            bus(1'h1, `IDX_PROT_NV, 8'hF5);
            bus(1'h1, `IDX_CTRL, 8'h07);
            rc(`IDX_STATUS, 8'h03);
            k = 0;
            rd = 8'h01;
            while (rd[0] !== 1'h0 && k < 100) begin
                bus(1'h0, `IDX_CTRL, 8'h00);
                k = k + 1;
            end
            chk(rd, 16'h06);
            chk(pump_seen, 16'h1);
            rc(`IDX_STATUS, 8'h02);
            bus(1'h1, `IDX_CTRL, 8'h04);
            bus(1'h1, `IDX_CTRL, 8'h00);
            rc(`IDX_PROT_MIR, 8'hFF);
            rc(`IDX_PROT_NV, 8'hF5);
            repeat (4) @(posedge pclk);
            chk({block_protect_bits, secure_area_lock}, 16'h0A);
            rc(`IDX_PROT_MIR, 8'hF5);
        end
    endtask
    // second reset in mid-run reloads from the cells
    task t_rereset;
        begin
            rst;
            rc(`IDX_DIV_LO, 8'hFF);
            rc(`IDX_DIV_HI, 8'h87);
            rc(`IDX_PROT_MIR, 8'hF5);
            chk({block_protect_bits, secure_area_lock}, 16'h0A);
        end
    endtask
    initial begin
        rst;
        t_reset_vals;
        t_writes;
        t_timebase;
        t_program;
        t_rereset;
        wrap_up;
    end
endmodule
